//--- design/cfg_port_pkg.sv
// Constants for the three-wire configuration serial port
package cfg_port_pkg;
   // Serial frame layout
   localparam int FRAME_W = 32;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 27;
   localparam int NUM_REGS = 32;
   localparam int NUM_CH = 6;
   localparam int NUM_REF = 3;
   // Output channel fields inside the data part of a frame
   localparam int DIV_LSB = 0;
   localparam int DIV_W = 11;
   localparam int DDLY_LSB = 11;
   localparam int DDLY_W = 10;
   localparam logic [10:0] DIV_LIMIT = 11'h019;
   localparam logic [9:0] DDLY_LIMIT = 10'h00c;
   localparam logic [1:0] EXTRA_CLOCKS = 2'h3;
   localparam logic [5:0] RB_BITS = 6'h20;
   // Clock
   localparam int CLK_PERIOD_NS = 50;
   // APB register offsets
   localparam int PADDR_W = 12;
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_STATUS = 12'h004;
   localparam logic [11:0] OFF_BIAS = 12'h008;
   localparam logic [11:0] OFF_BANK = 12'h080;
   // Control register fields
   localparam int CTRL_AUTOSYNC = 0;
   localparam int CTRL_RBLE = 1;
   localparam int CTRL_RBADDR_LSB = 4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // Status register fields
   localparam int ST_ADDR_LSB = 0;
   localparam int ST_PENDING = 5;
   localparam int ST_EARLY_SYNC = 6;
   localparam int ST_RB_ACTIVE = 7;
   localparam int ST_REF_LSB = 8;
   localparam int ST_APPLIED_LSB = 16;
   localparam int ST_FRAMES_LSB = 24;
   // Status pin bias, two bits per pin
   localparam logic [1:0] BIAS_HIZ = 2'h0;
   localparam logic [1:0] BIAS_PULLUP = 2'h1;
   localparam logic [1:0] BIAS_PULLDOWN = 2'h2;
   localparam logic [5:0] BIAS_RESET = 6'h00;
endpackage

//--- design/sync_edge.sv
// Two-flop synchroniser with edge detection for one pin
`timescale 1ns/100ps
module sync_edge (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Asynchronous pin
   input wire logic din,
   // Synchronised level and edges
   output logic level,
   output logic rise,
   output logic fall
);
   logic s1;
   logic s2;
   logic s3;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // Only the second and third stages are looked at
   assign level = s2;
   assign rise = s2 & ~s3;
   assign fall = ~s2 & s3;
endmodule

//--- design/cfg_reg_bank.sv
// Bank of configuration registers with one write and two read ports
`timescale 1ns/100ps
module cfg_reg_bank (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Write port
   input wire logic we,
   input wire logic [4:0] waddr,
   input wire logic [26:0] wdata,
   // Read ports
   input wire logic [4:0] raddr_a,
   output logic [26:0] rdata_a,
   input wire logic [4:0] raddr_b,
   output logic [26:0] rdata_b
);
   logic [26:0] mem [cfg_port_pkg::NUM_REGS];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < cfg_port_pkg::NUM_REGS; i++) begin
            mem[i] <= 27'h0;
         end
      end else if (we) begin
         mem[waddr] <= wdata;
      end
   end

   assign rdata_a = mem[raddr_a];
   assign rdata_b = mem[raddr_b];
endmodule

//--- design/three_wire_config_serial_port.sv
// Three-wire serial configuration port with APB access
//
// Functional notes
// R1 - Shift data bit in on each clock rise
// R2 - Latch rise copies word to addressed register
// R3 - Host parks lines low after programming
// R4 - Large channel values need extra clocks
// R5 - Auto sync needs extra clocks, latch high
// R6 - Auto sync fires on latch falling edge
// R7 - Readback keeps shifting input data in
// R8 - Latch after readback stores shifted bits
// R9 - Address is last five bits shifted
// R10 - Readback bit changes after clock fall
// R11 - Readback works with either latch setting
// R12 - Status pin bias from two-bit type
// R13 - 32-bit frame, MSB first, address last
`timescale 1ns/100ps
module three_wire_config_serial_port (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic PREADY,
   output logic [31:0] PRDATA,
   output logic PSLVERR,
   // Serial programming pins
   input wire logic SERIAL_PROG_CLOCK,
   input wire logic SERIAL_PROG_DATA,
   input wire logic SERIAL_LATCH_ENABLE,
   // Readback pin
   output logic READBACK_DATA,
   output logic READBACK_OE_N,
   // Output synchronisation event
   output logic SYNC_PULSE,
   // Reference status pins used as inputs
   input wire logic [2:0] REF_STATUS_PIN,
   output logic [2:0] REF_STATUS_PULL_UP,
   output logic [2:0] REF_STATUS_PULL_DOWN
);
   logic sck_rise;
   logic sck_fall;
   logic sdi_level;
   logic armed;
   logic le_rise;
   logic le_fall;
   logic [2:0] ref_level;
   logic [31:0] shift_reg;
   logic [31:0] ctrl;
   logic [5:0] bias;
   logic [4:0] last_addr;
   logic pending;
   logic [4:0] pending_addr;
   logic [1:0] extra_cnt;
   logic early_sync;
   logic [5:0] applied;
   logic [7:0] frames;
   logic [31:0] rb_shift;
   logic [5:0] rb_cnt;
   logic rb_active;
   logic [26:0] bank_rdata;
   logic [26:0] rb_rdata;
   logic [4:0] frame_addr;
   logic [26:0] frame_data;
   logic large_value;
   logic is_channel;
   logic repeat_write;
   logic commit;
   logic rb_load;
   logic apb_setup;
   logic apb_write;
   logic bank_hit;
   logic [31:0] next_prdata;
   logic next_pslverr;
   logic [31:0] status;

   // Pins cross into the CLK domain before any use
   sync_edge u_sync_sck (
      .clk(CLK),
      .rst_n(RST_N),
      .din(SERIAL_PROG_CLOCK),
      .level(),
      .rise(sck_rise),
      .fall(sck_fall)
   );

   sync_edge u_sync_sdi (
      .clk(CLK),
      .rst_n(RST_N),
      .din(SERIAL_PROG_DATA),
      .level(sdi_level),
      .rise(),
      .fall()
   );

   sync_edge u_sync_le (
      .clk(CLK),
      .rst_n(RST_N),
      .din(SERIAL_LATCH_ENABLE),
      .level(),
      .rise(le_rise),
      .fall(le_fall)
   );

   generate
      for (genvar g = 0; g < cfg_port_pkg::NUM_REF; g++) begin : g_ref
         sync_edge u_sync_ref (
            .clk(CLK),
            .rst_n(RST_N),
            .din(REF_STATUS_PIN[g]),
            .level(ref_level[g]),
            .rise(),
            .fall()
         );
      end
   endgenerate

   // Data and clock go through equal stages, so they stay aligned
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         shift_reg <= 32'h0;
      end else if (sck_rise) begin
         shift_reg <= {shift_reg[30:0], sdi_level}; // R1 R7 R13
      end
   end

   assign frame_addr = shift_reg[4:0]; // R9 R13
   assign frame_data = shift_reg[31:5]; // R13
   assign is_channel = frame_addr < 5'(cfg_port_pkg::NUM_CH);
   assign large_value =
      (frame_data[cfg_port_pkg::DDLY_LSB-1:cfg_port_pkg::DIV_LSB] >
       cfg_port_pkg::DIV_LIMIT) ||
      (frame_data[cfg_port_pkg::DDLY_LSB+cfg_port_pkg::DDLY_W-1:
                  cfg_port_pkg::DDLY_LSB] > cfg_port_pkg::DDLY_LIMIT);
   // The next frame's clocks already commit a pending value, so a second
   // latch to that channel still has to count as the repeat
   assign repeat_write = le_rise && (pending || armed) &&
                         (frame_addr == pending_addr);

   // Every latch rise stores the word, readback frames included
   cfg_reg_bank u_bank (
      .clk(CLK),
      .rst_n(RST_N),
      .we(le_rise), // R2 R8
      .waddr(frame_addr),
      .wdata(frame_data),
      .raddr_a(PADDR[6:2]),
      .rdata_a(bank_rdata),
      .raddr_b(ctrl[cfg_port_pkg::CTRL_RBADDR_LSB+:5]),
      .rdata_b(rb_rdata)
   );

   // A large channel value waits for three more clock rises or a repeat
   assign commit = (pending && sck_rise &&
                    extra_cnt == cfg_port_pkg::EXTRA_CLOCKS - 2'h1) ||
                   repeat_write; // R4

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         pending <= 1'b0;
         pending_addr <= 5'h0;
         extra_cnt <= 2'h0;
         armed <= 1'b0;
      end else if (le_rise && is_channel && large_value && !repeat_write) begin
         pending <= 1'b1;
         pending_addr <= frame_addr;
         extra_cnt <= 2'h0;
         armed <= 1'b0;
      end else if (commit) begin
         pending <= 1'b0;
         extra_cnt <= 2'h0;
         armed <= !le_rise; // R4
      end else if (pending && sck_rise) begin
         extra_cnt <= extra_cnt + 2'h1; // R4 R5
      end else if (le_rise) begin
         armed <= 1'b0;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         applied <= 6'h3f;
      end else begin
         for (int i = 0; i < cfg_port_pkg::NUM_CH; i++) begin
            if (commit && pending_addr == 5'(i)) begin
               applied[i] <= 1'b1; // R4
            end else if (le_rise && frame_addr == 5'(i)) begin
               applied[i] <= !large_value;
            end
         end
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         last_addr <= 5'h0;
         frames <= 8'h00;
      end else if (le_rise) begin
         last_addr <= frame_addr;
         frames <= frames + 8'h01;
      end
   end

   // Sync on latch fall; a value still pending then is flagged
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         SYNC_PULSE <= 1'b0;
      end else begin
         SYNC_PULSE <= le_fall && ctrl[cfg_port_pkg::CTRL_AUTOSYNC]; // R6
      end
   end

   // Set wins over a software clear in the same cycle
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         early_sync <= 1'b0;
      end else if (le_fall && ctrl[cfg_port_pkg::CTRL_AUTOSYNC] &&
                   pending) begin
         early_sync <= 1'b1; // R5
      end else if (apb_write && PADDR == cfg_port_pkg::OFF_STATUS &&
                   PWDATA[cfg_port_pkg::ST_EARLY_SYNC]) begin
         early_sync <= 1'b0;
      end
   end

   // Readback load edge follows the latch setting
   assign rb_load = ctrl[cfg_port_pkg::CTRL_RBLE] ? le_rise : le_fall; // R11

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rb_shift <= 32'h0;
         rb_cnt <= 6'h00;
         rb_active <= 1'b0;
      end else if (rb_load) begin
         rb_shift <= {rb_rdata, ctrl[cfg_port_pkg::CTRL_RBADDR_LSB+:5]};
         rb_cnt <= 6'h00;
         rb_active <= 1'b1;
      end else if (rb_active && sck_fall) begin
         rb_shift <= {rb_shift[30:0], 1'b0}; // R10
         rb_cnt <= rb_cnt + 6'h01;
         rb_active <= rb_cnt != cfg_port_pkg::RB_BITS - 6'h01;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         READBACK_DATA <= 1'b0;
         READBACK_OE_N <= 1'b1;
      end else begin
         READBACK_DATA <= rb_shift[31]; // R10
         READBACK_OE_N <= !rb_active;
      end
   end

   // Status pin bias; code 3 is left floating
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         REF_STATUS_PULL_UP <= 3'h0;
         REF_STATUS_PULL_DOWN <= 3'h0;
      end else begin
         for (int i = 0; i < cfg_port_pkg::NUM_REF; i++) begin
            REF_STATUS_PULL_UP[i] <= bias[2*i+:2] == cfg_port_pkg::BIAS_PULLUP;
            REF_STATUS_PULL_DOWN[i] <=
               bias[2*i+:2] == cfg_port_pkg::BIAS_PULLDOWN; // R12
         end
      end
   end

   // APB slave, zero wait states
   assign PREADY = 1'b1;
   assign apb_setup = PSEL && !PENABLE;
   assign apb_write = PSEL && PENABLE && PWRITE;
   assign bank_hit = PADDR[11:7] == cfg_port_pkg::OFF_BANK[11:7] &&
                     PADDR[1:0] == 2'h0;

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ctrl <= cfg_port_pkg::CTRL_RESET;
         bias <= cfg_port_pkg::BIAS_RESET;
      end else if (apb_write) begin
         if (PADDR == cfg_port_pkg::OFF_CTRL) begin
            ctrl <= {23'h0, PWDATA[8:4], 2'h0, PWDATA[1:0]};
         end
         if (PADDR == cfg_port_pkg::OFF_BIAS) begin
            bias <= PWDATA[5:0];
         end
      end
   end

   always_comb begin
      status = 32'h0;
      status[cfg_port_pkg::ST_ADDR_LSB+:5] = last_addr;
      status[cfg_port_pkg::ST_PENDING] = pending;
      status[cfg_port_pkg::ST_EARLY_SYNC] = early_sync;
      status[cfg_port_pkg::ST_RB_ACTIVE] = rb_active;
      status[cfg_port_pkg::ST_REF_LSB+:3] = ref_level;
      status[cfg_port_pkg::ST_APPLIED_LSB+:6] = applied;
      status[cfg_port_pkg::ST_FRAMES_LSB+:8] = frames;
   end

   always_comb begin
      next_prdata = 32'h0;
      next_pslverr = 1'b0;
      if (PADDR == cfg_port_pkg::OFF_CTRL) begin
         next_prdata = ctrl;
      end else if (PADDR == cfg_port_pkg::OFF_STATUS) begin
         next_prdata = status;
      end else if (PADDR == cfg_port_pkg::OFF_BIAS) begin
         next_prdata = {26'h0, bias};
      end else if (bank_hit) begin
         next_prdata = {5'h0, bank_rdata};
         next_pslverr = PWRITE;
      end else begin
         next_pslverr = 1'b1;
      end
   end

   // Read data is captured in the setup cycle and held through access
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         PRDATA <= 32'h0;
         PSLVERR <= 1'b0;
      end else if (apb_setup) begin
         PRDATA <= PWRITE ? 32'h0 : next_prdata;
         PSLVERR <= next_pslverr;
      end
   end
endmodule

//--- tb/cfg_port_chk.sv
// Checker on the ports of the configuration serial port
`timescale 1ns/100ps
module cfg_port_chk (
   // Clock, reset and bus
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic PREADY,
   input wire logic [31:0] PRDATA,
   input wire logic PSLVERR,
   // Serial side
   input wire logic SERIAL_PROG_CLOCK,
   input wire logic SERIAL_LATCH_ENABLE,
   input wire logic READBACK_DATA,
   input wire logic READBACK_OE_N,
   input wire logic SYNC_PULSE,
   input wire logic [2:0] REF_STATUS_PULL_UP,
   input wire logic [2:0] REF_STATUS_PULL_DOWN
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   logic setup;
   logic unmapped;
   logic bank_win;
   logic both_pulls;
   assign setup = PSEL && !PENABLE;
   assign unmapped = PADDR > 12'h0fc || PADDR[1:0] != 2'h0 ||
      (PADDR > 12'h008 && PADDR < 12'h080);
   assign bank_win = PADDR[11:7] == 5'h01;
   assign both_pulls = |(REF_STATUS_PULL_UP & REF_STATUS_PULL_DOWN);
   sequence le_fell;
      $fell(SERIAL_LATCH_ENABLE);
   endsequence
   sequence rb_start;
      $fell(READBACK_OE_N);
   endsequence
   sequence sync_start;
      $rose(SYNC_PULSE);
   endsequence
   sequence rb_moved;
      !READBACK_OE_N && $past(!READBACK_OE_N) && $changed(READBACK_DATA);
   endsequence
   sequence refused;
      PSLVERR && PRDATA == 32'h0;
   endsequence
   chk_ready_high: assert property (PREADY)
      else $error("ready low");
   chk_unmapped_err: assert property (setup && unmapped |=> refused)
      else $error("unmapped access not refused");
   chk_bank_ro: assert property (setup && PWRITE && bank_win |=> PSLVERR)
      else $error("bank write not refused");
   chk_mapped_ok: assert property (setup && !unmapped && !PWRITE |=> !PSLVERR)
      else $error("mapped read refused");
   chk_sync_single: assert property (SYNC_PULSE |=> !SYNC_PULSE)
      else $error("sync pulse too long");
   chk_sync_le_low: assert property (sync_start |-> !SERIAL_LATCH_ENABLE)
      else $error("sync while latch high");
   chk_sync_delay: assert property (le_fell |-> !SYNC_PULSE [*2])
      else $error("sync too early");
   chk_rb_length: assert property (rb_start |-> !READBACK_OE_N [*8])
      else $error("readback too short");
   chk_rb_on_fall: assert property (rb_moved |-> !SERIAL_PROG_CLOCK)
      else $error("readback bit moved while clock high");
   chk_pull_excl: assert property (!both_pulls)
      else $error("pull up and down together");
endmodule
bind three_wire_config_serial_port cfg_port_chk u_chk (.CLK, .RST_N, .PSEL,
   .PENABLE, .PWRITE, .PADDR, .PREADY, .PRDATA, .PSLVERR, .SERIAL_PROG_CLOCK,
   .SERIAL_LATCH_ENABLE, .READBACK_DATA, .READBACK_OE_N, .SYNC_PULSE,
   .REF_STATUS_PULL_UP, .REF_STATUS_PULL_DOWN);

//--- tb/serial_host.sv
// Host model driving the three serial programming pins
`timescale 1ns/100ps
module serial_host (
   // Clock
   input wire logic clk,
   // Serial pins
   output logic sclk,
   output logic sdata,
   output logic le,
   input wire logic rb_data
);
   initial begin
      sclk = 1'b0;
      sdata = 1'b0;
      le = 1'b0;
   end
   // Six cycles per level so the synchronised edges are always seen
   task automatic pulses(input int n);
      repeat (n) begin
         sclk <= 1'b1;
         repeat (6) @(posedge clk);
         sclk <= 1'b0;
         repeat (6) @(posedge clk);
      end
   endtask
   task automatic send(input logic [31:0] w, input bit xle,
      output logic [31:0] rb);
      for (int i = 31; i >= 0; i--) begin
         sdata <= w[i];
         repeat (6) @(posedge clk);
         sclk <= 1'b1;
         rb[i] = rb_data;
         repeat (6) @(posedge clk);
         sclk <= 1'b0;
      end
      repeat (6) @(posedge clk);
      le <= 1'b1;
      repeat (6) @(posedge clk);
      if (xle) begin
         pulses(3);
      end
      le <= 1'b0;
      sdata <= 1'b0;
      repeat (6) @(posedge clk);
   endtask
endmodule

//--- tb/three_wire_config_serial_port_test.sv
// Testbench for the three-wire configuration serial port
`timescale 1ns/100ps
module three_wire_config_serial_port_test;
   typedef struct packed {logic w; logic err; logic [31:0] d;} note_t;
   logic CLK = 1'b0;
   logic RST_N = 1'b0;
   logic PSEL, PENABLE, PWRITE, PREADY, PSLVERR, READBACK_DATA, SYNC_PULSE;
   logic READBACK_OE_N, rb_pin;
   logic [11:0] PADDR;
   logic [31:0] PWDATA, PRDATA, last_rb;
   logic [2:0] REF_STATUS_PIN, REF_STATUS_PULL_UP, REF_STATUS_PULL_DOWN;
   logic [2:0] pu, pd;
   logic sclk, sdata, le;
   logic [4:0] a;
   logic [26:0] d, d2;
   logic [5:0] b;
   note_t notes[$];
   note_t nt;
   int num_errors = 0;
   int checks = 0;
   int syncs = 0;
   int frames = 0;
   always #25 CLK = ~CLK;
   // A released readback pin shows the inverse of its last bit
   assign rb_pin = READBACK_OE_N ? ~READBACK_DATA : READBACK_DATA;
   serial_host u_serial_host (.clk(CLK), .sclk(sclk), .sdata(sdata),
      .le(le), .rb_data(rb_pin));
   three_wire_config_serial_port u_three_wire_config_serial_port (.CLK,
      .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PREADY, .PRDATA,
      .PSLVERR, .SERIAL_PROG_CLOCK(sclk), .SERIAL_PROG_DATA(sdata),
      .SERIAL_LATCH_ENABLE(le), .READBACK_DATA, .READBACK_OE_N,
      .SYNC_PULSE, .REF_STATUS_PIN, .REF_STATUS_PULL_UP,
      .REF_STATUS_PULL_DOWN);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] ad,
      input logic [31:0] dt, input logic err);
      int n = 0;
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= w;
      PADDR <= ad;
      PWDATA <= dt;
      notes.push_back(note_t'({w, err, dt}));
      @(posedge CLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge CLK);
         n++;
      end while (PREADY !== 1'b1 && n < 16);
      if (n >= 16) begin
         num_errors++;
         results();
      end
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLK);
   endtask
   task automatic frame(input logic [4:0] fa, input logic [26:0] fd,
      input bit xle);
      u_serial_host.send({fd, fa}, xle, last_rb);
      frames++;
   endtask
   function automatic logic [31:0] stat(input logic [4:0] sa, input logic p,
      input logic e, input logic [5:0] ap);
      // Every latch event reloads the readback word, so it stays active
      return {frames[7:0], 2'h0, ap, 5'h0, REF_STATUS_PIN,
         frames != 0, e, p, sa};
   endfunction
   function automatic logic [11:0] bank(input logic [4:0] ba);
      return 12'h080 | {5'h0, ba, 2'h0};
   endfunction
   // Read and write results are compared as they appear on the bus
   always @(posedge CLK) begin
      if (PSEL && PENABLE && PREADY) begin
         nt = notes.pop_front();
         check(PSLVERR, nt.err);
         if (!nt.w) check(PRDATA, nt.d);
      end
      if (SYNC_PULSE === 1'b1) syncs++;
   end
   initial begin
      repeat (100000) @(posedge CLK);
      num_errors++;
      results();
   end
   initial begin
      PSEL = 1'b0;
      PENABLE = 1'b0;
      PWRITE = 1'b0;
      PADDR = 12'h000;
      PWDATA = 32'h0;
      void'($urandom(32'h3f408078));
      REF_STATUS_PIN = 3'($urandom);
      repeat (8) @(posedge CLK);
      RST_N <= 1'b1;
      repeat (4) @(posedge CLK);
      apb(0, 12'h000, 32'h0, 0);
      apb(0, 12'h004, stat(5'h0, 0, 0, 6'h3f), 0);
      apb(0, 12'h008, 32'h0, 0);
      apb(0, 12'h00c, 32'h0, 1);
      apb(0, 12'h100, 32'h0, 1);
      apb(1, 12'h080, 32'h1, 1);
      for (int i = 0; i < 4; i++) begin
         a = (i == 0) ? 5'h1f : 5'h06 + 5'($urandom % 25);
         d = 27'($urandom);
         frame(a, d, 0);
         apb(0, bank(a), {5'h0, d}, 0);
      end
      apb(0, 12'h004, stat(a, 0, 0, 6'h3f), 0);
      // Boundary values: delay 12 is plain, divide 26 needs extra clocks
      frame(5'h2, {6'h0, 10'h00c, 11'h019}, 0);
      apb(0, 12'h004, stat(5'h2, 0, 0, 6'h3f), 0);
      frame(5'h2, {6'h0, 10'h000, 11'h01a}, 0);
      apb(0, 12'h004, stat(5'h2, 1, 0, 6'h3b), 0);
      u_serial_host.pulses(3);
      apb(0, 12'h004, stat(5'h2, 0, 0, 6'h3f), 0);
      frame(5'h4, {6'h0, 10'h00d, 11'h000}, 0);
      frame(5'h4, {6'h0, 10'h00d, 11'h000}, 0);
      apb(0, 12'h004, stat(5'h4, 0, 0, 6'h3f), 0);
      apb(1, 12'h000, 32'h1, 0);
      frame(5'h1, {6'h0, 10'h00d, 11'h000}, 1);
      apb(0, 12'h004, stat(5'h1, 0, 0, 6'h3f), 0);
      check(syncs, 1);
      // Missing extra clocks leave the sync too early, which is sticky
      frame(5'h3, {6'h0, 10'h000, 11'h7ff}, 0);
      u_serial_host.pulses(3);
      apb(0, 12'h004, stat(5'h3, 0, 1, 6'h3f), 0);
      apb(1, 12'h004, 32'h40, 0);
      apb(0, 12'h004, stat(5'h3, 0, 0, 6'h3f), 0);
      check(syncs, 2);
      for (int s = 0; s < 2; s++) begin
         a = 5'h08 + 5'(s);
         d = 27'($urandom);
         d2 = 27'($urandom);
         apb(1, 12'h000, {23'h0, a, 2'h0, s[0], 1'b0}, 0);
         frame(a, d, 0);
         frame(a, d, 0);
         frame(a, d2, 0);
         check(last_rb, {d, a});
         check(READBACK_OE_N, 1'b0);
         apb(0, bank(a), {5'h0, d2}, 0);
      end
      for (int i = 0; i < 4; i++) begin
         b = (i == 0) ? 6'h24 : 6'($urandom);
         apb(1, 12'h008, {26'h0, b}, 0);
         apb(0, 12'h008, {26'h0, b}, 0);
         for (int j = 0; j < 3; j++) begin
            pu[j] = (b[2*j +: 2] == 2'h1);
            pd[j] = (b[2*j +: 2] == 2'h2);
         end
         check(REF_STATUS_PULL_UP, pu);
         check(REF_STATUS_PULL_DOWN, pd);
      end
      results();
   end
endmodule
